// [hdl/adcmc_top.sv]
// Purpose: Converter controller: sequencer, control cores, sync, merge,
//          sample storage and limit checks around the hard converter
// Assumes: Hard block pins are sampled on ref_clk; end of conversion is
//          resynchronised as it comes from the converter clock
// Notes: Notes on behaviour below
// Notes on behaviour
// - Control core takes stream commands, decodes them, drives the hard block.
// - Sequencer holds a mode command register and a fixed slot sequence.
// - Sequence length and slot channels are build parameters only.
// - Host reads and writes the sequencer command register.
// - Sequencer streams commands downstream in slot order.
// - Storage writes each sample to RAM; host reads RAM.
// - Optional interrupt after each complete pass through the sequence.
// - Merge combines simultaneous responses of two cores into one packet.
// - Merge exists for two converters, with or without on-chip storage.
// - Two-converter build has a synchronizer keeping conversions aligned.
// - Cores flag sync valid; sync ready after both; cores advance together.
// - Limit check flags samples above maximum or below minimum.
// - Each limit violation leaves as a stream transfer.
// - Limit enables and values are build parameters only.
// - Command channel numbers are translated to hard block selections.
// - Only power up, power down, pin and temperature conversions.
// - Soft logic and converter clock events cross safely.
// - Control core has no run-time settings.
// - Ready only when able to convert; one command outstanding at most.
// - Ready returns once the current command is done.
`timescale 1ns/1ps
`include "adcmc_regs.svh"
module adcmc_top #(
  parameter int NUM_ADC = 1,
  parameter bit HAS_STORAGE = 1'b1,
  parameter int SEQ_LEN = 4,
  parameter logic [`ADCMC_MAX_SLOTS*5-1:0] SLOT_CH = 320'h88C41,
  parameter logic [`ADCMC_MAX_SLOTS*5-1:0] SLOT_CH2 = 320'hF8C41,
  parameter logic [31:0] MAX_EN = 32'h0000_0000,
  parameter logic [31:0] MIN_EN = 32'h0000_0000,
  parameter logic [11:0] MAX_VAL = 12'hFFF,
  parameter logic [11:0] MIN_VAL = 12'h000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic seqCmdWrite,
  input wire logic [`ADCMC_CMD_W-1:0] seqCmdWdata,
  output logic [`ADCMC_CMD_W-1:0] seqCmdRdata,
  input wire logic [5:0] ramRdAddr,
  output logic [NUM_ADC*12-1:0] ramRdData,
  input wire logic irqEnable,
  input wire logic irqClear,
  output logic irq,
  output logic [NUM_ADC-1:0] adcSoc,
  output logic [NUM_ADC-1:0] adcPowerDown,
  output logic [NUM_ADC-1:0] adcTempSense,
  output logic [NUM_ADC*5-1:0] adcChanSel,
  input wire logic [NUM_ADC-1:0] adcEoc,
  input wire logic [NUM_ADC*12-1:0] adcDout,
  output adcmc_pkg::adcmc_rsp_s resp,
  output logic [NUM_ADC*12-1:0] respData,
  output logic [NUM_ADC-1:0] violValid,
  output logic [NUM_ADC*5-1:0] violChannel,
  output logic [NUM_ADC-1:0] violAboveMax,
  output logic [NUM_ADC-1:0] violBelowMin
);
  localparam logic [7:0] GAP_LAST = 8'(`ADCMC_RSP_GAP_CYC - 1);
  localparam logic [7:0] PWRUP_LAST = 8'(`ADCMC_PWRUP_CYC - 1);
  localparam logic [7:0] CONT_WIN = 8'(`ADCMC_CONT_WIN_CYC);
  localparam logic [5:0] LAST_SLOT = 6'(SEQ_LEN - 1);
  // Reset image of the command register, picked apart bit by bit
  localparam logic [`ADCMC_CMD_W-1:0] CMD_RST = `ADCMC_CMD_RESET;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic seqRun_r, seqMode_r, seqValid_r, pdPend_r, cmdReady_r;
  logic [5:0] slot_r;
  adcmc_pkg::adcmc_cmd_s cmd;

  // Handshake on valid and ready; fields are sampled in that cycle
  wire take = seqValid_r & cmdReady_r;
  wire lastSlot = (slot_r == LAST_SLOT);
  wire passEnd = take & ~pdPend_r & lastSlot;
  wire swRun = seqCmdWrite & seqCmdWdata[`ADCMC_CMD_RUN_BIT];
  // Single mode stops itself at the pass end; a clear takes effect at the pass end too
  wire hwStop = passEnd & (~seqMode_r | ~seqRun_r);
  wire runNxt = swRun | (seqCmdWrite ? 1'b0 : (seqRun_r & ~hwStop));
  wire [5:0] slotNxt = take & ~pdPend_r ? (lastSlot ? 6'h00 : slot_r + 6'h01) : slot_r;
  wire pdPendNxt = (pdPend_r & ~take) | hwStop;

  // Command presented from the current slot, in slot order
  always_comb begin
    cmd.op = pdPend_r ? adcmc_pkg::OP_PWRDOWN : adcmc_pkg::OP_CONVERT;
    cmd.slot = slot_r;
    cmd.sop = (slot_r == 6'h00);
    cmd.eop = lastSlot;
  end

  // Set by software wins over the self-clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seqRun_r <= CMD_RST[`ADCMC_CMD_RUN_BIT];
      seqMode_r <= CMD_RST[`ADCMC_CMD_MODE_BIT];
      slot_r <= 6'h00;
      pdPend_r <= 1'b0;
      seqValid_r <= 1'b0;
      seqCmdRdata <= `ADCMC_CMD_RESET;
    end else begin
      seqRun_r <= runNxt;
      if (seqCmdWrite) begin
        seqMode_r <= seqCmdWdata[`ADCMC_CMD_MODE_BIT];
      end
      slot_r <= slotNxt;
      pdPend_r <= pdPendNxt;
      seqValid_r <= runNxt | (slotNxt != 6'h00) | pdPendNxt;
      seqCmdRdata <= {seqCmdWrite ? seqCmdWdata[`ADCMC_CMD_MODE_BIT] : seqMode_r, runNxt};
    end
  end

  // ----------------------------------------
  // Control cores and synchronizer
  // ----------------------------------------
  logic [NUM_ADC-1:0] coreReadyNxt, syncValid;
  logic [NUM_ADC*12-1:0] samples;
  logic syncReady_r;

  for (genvar k = 0; k < NUM_ADC; k++) begin : gCore
    adcmc_pkg::adcmc_state_e state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic soc_r, soc_nxt, pd_r, pd_nxt, tsen_r, tsen_nxt, sv_r, sv_nxt;
    logic [4:0] chsel_r, chsel_nxt;
    logic [11:0] smp_r, smp_nxt;
    logic [2:0] eocSync_r;
    logic isNull_r, isNull_nxt;

    // Slot to hard block selection; second core uses its own table
    wire [4:0] slotCh = (k == 0) ? SLOT_CH[cmd.slot*5 +: 5] : SLOT_CH2[cmd.slot*5 +: 5];
    wire isTsd = (slotCh == `ADCMC_TSD_CH);
    wire [4:0] hwSel = isTsd ? `ADCMC_TSD_HW_SEL : slotCh;
    // Only the last two stages feed the edge detector
    wire eocRise = eocSync_r[1] & ~eocSync_r[2];
    wire takeConv = take & (cmd.op == adcmc_pkg::OP_CONVERT);
    wire takePd = take & (cmd.op == adcmc_pkg::OP_PWRDOWN);

    always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      soc_nxt = soc_r;
      pd_nxt = pd_r;
      tsen_nxt = tsen_r;
      chsel_nxt = chsel_r;
      sv_nxt = sv_r;
      smp_nxt = smp_r;
      isNull_nxt = isNull_r;
      case (state_r)
        adcmc_pkg::ST_OFF: begin
          if (takeConv) begin
            state_nxt = adcmc_pkg::ST_PWRUP;
            pd_nxt = 1'b0;
            cnt_nxt = 8'h00;
            chsel_nxt = hwSel;
            tsen_nxt = isTsd;
            isNull_nxt = (slotCh == `ADCMC_NULL_CH);
          end
        end
        adcmc_pkg::ST_PWRUP: begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == PWRUP_LAST) begin
            state_nxt = adcmc_pkg::ST_CONV;
            soc_nxt = 1'b1;
          end
        end
        adcmc_pkg::ST_IDLE: begin
          if (takePd) begin
            state_nxt = adcmc_pkg::ST_OFF;
            pd_nxt = 1'b1;
            soc_nxt = 1'b0;
            tsen_nxt = 1'b0;
          end else if (takeConv) begin
            state_nxt = adcmc_pkg::ST_CONV;
            soc_nxt = 1'b1;
            chsel_nxt = hwSel;
            tsen_nxt = isTsd;
            isNull_nxt = (slotCh == `ADCMC_NULL_CH);
          end else if (cnt_r == CONT_WIN) begin
            soc_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
        adcmc_pkg::ST_CONV: begin
          if (eocRise) begin
            state_nxt = adcmc_pkg::ST_SYNC;
            sv_nxt = 1'b1;
            // Empty slot of the second converter reads as zero
            smp_nxt = isNull_r ? 12'h000 : adcDout[k*12 +: 12];
          end
        end
        adcmc_pkg::ST_SYNC: begin
          if (syncReady_r) begin
            state_nxt = adcmc_pkg::ST_GAP;
            sv_nxt = 1'b0;
            cnt_nxt = 8'h00;
          end
        end
        adcmc_pkg::ST_GAP: begin
          // Holds ready low so responses keep their least spacing
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == GAP_LAST) begin
            state_nxt = adcmc_pkg::ST_IDLE;
            cnt_nxt = 8'h00;
          end
        end
        default: begin
          state_nxt = adcmc_pkg::ST_OFF;
        end
      endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        state_r <= adcmc_pkg::ST_OFF;
        cnt_r <= 8'h00;
        soc_r <= 1'b0;
        pd_r <= 1'b1;
        tsen_r <= 1'b0;
        chsel_r <= 5'h00;
        sv_r <= 1'b0;
        smp_r <= 12'h000;
        isNull_r <= 1'b0;
        eocSync_r <= 3'h0;
      end else begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        soc_r <= soc_nxt;
        pd_r <= pd_nxt;
        tsen_r <= tsen_nxt;
        chsel_r <= chsel_nxt;
        sv_r <= sv_nxt;
        smp_r <= smp_nxt;
        isNull_r <= isNull_nxt;
        eocSync_r <= {eocSync_r[1:0], adcEoc[k]};
      end
    end

    // Ready only in a state that can start a conversion
    assign coreReadyNxt[k] = (state_nxt == adcmc_pkg::ST_IDLE) |
                             (state_nxt == adcmc_pkg::ST_OFF);
    assign syncValid[k] = sv_r;
    assign samples[k*12 +: 12] = smp_r;
    assign adcSoc[k] = soc_r;
    assign adcPowerDown[k] = pd_r;
    assign adcTempSense[k] = tsen_r;
    assign adcChanSel[k*5 +: 5] = chsel_r;
  end

  // Ready drops the cycle after a conversion take, so one command is outstanding
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmdReady_r <= 1'b0;
      syncReady_r <= 1'b0;
    end else begin
      cmdReady_r <= &coreReadyNxt;
      syncReady_r <= (&syncValid) & ~syncReady_r;
    end
  end

  // ----------------------------------------
  // Response and merge
  // ----------------------------------------
  logic [5:0] curSlot_r;
  logic [4:0] curCh_r;
  logic curSop_r, curEop_r;

  // Command fields kept for the response of the conversion in flight
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      curSlot_r <= 6'h00;
      curCh_r <= 5'h00;
      curSop_r <= 1'b0;
      curEop_r <= 1'b0;
    end else if (take && cmd.op == adcmc_pkg::OP_CONVERT) begin
      curSlot_r <= cmd.slot;
      curCh_r <= SLOT_CH[cmd.slot*5 +: 5];
      curSop_r <= cmd.sop;
      curEop_r <= cmd.eop;
    end
  end

  // All converter samples leave in one packet; nothing can stall it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      resp <= '0;
      respData <= '0;
    end else begin
      resp.valid <= syncReady_r;
      resp.slot <= curSlot_r;
      resp.channel <= curCh_r;
      resp.sop <= curSop_r;
      resp.eop <= curEop_r;
      respData <= samples;
    end
  end

  // ----------------------------------------
  // Sample storage and limit checks
  // ----------------------------------------
  if (HAS_STORAGE) begin : gStore
    // With two converters this stores the merged packet
    adcmc_sample_ram #(.W(NUM_ADC*12), .DEPTH(`ADCMC_MAX_SLOTS), .AW(6)) uRam (
      .ref_clk(ref_clk),
      .wrEn(resp.valid),
      .wrAddr(resp.slot),
      .wrData(respData),
      .rdAddr(ramRdAddr),
      .rdData(ramRdData)
    );

    // Block flag: a new pass end wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        irq <= 1'b0;
      end else begin
        irq <= (resp.valid & resp.eop & irqEnable) | (irq & ~irqClear);
      end
    end
  end else begin : gNoStore
    assign ramRdData = '0;
    assign irq = 1'b0;
  end

  for (genvar k = 0; k < NUM_ADC; k++) begin : gThr
    adcmc_threshold #(
      .MAX_EN(MAX_EN),
      .MIN_EN(MIN_EN),
      .MAX_VAL(MAX_VAL),
      .MIN_VAL(MIN_VAL)
    ) uThr (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .smpValid(resp.valid),
      .smpChannel(resp.channel),
      .smpData(respData[k*12 +: 12]),
      .violValid(violValid[k]),
      .violChannel(violChannel[k*5 +: 5]),
      .violAboveMax(violAboveMax[k]),
      .violBelowMin(violBelowMin[k])
    );
  end
endmodule

// [hdl/adcmc_regs.svh]
// Purpose: Constants shared by the converter controller files
// Assumes: 50 MHz ref_clk, a period of 20 ns
// Notes: Definitions only
`ifndef ADCMC_REGS_SVH
`define ADCMC_REGS_SVH

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define ADCMC_CMD_W 2
`define ADCMC_CMD_RUN_BIT 0
`define ADCMC_CMD_MODE_BIT 1
`define ADCMC_CMD_RESET 2'h0

// ----------------------------------------
// Channel codes and field widths
// ----------------------------------------
`define ADCMC_MAX_SLOTS 64
`define ADCMC_CH_W 5
`define ADCMC_SMP_W 12
`define ADCMC_TSD_CH 5'h11
`define ADCMC_NULL_CH 5'h1F
`define ADCMC_TSD_HW_SEL 5'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCMC_CLK_NS 20
`define ADCMC_RSP_GAP_NS 1000
`define ADCMC_PWRUP_NS 1000
`define ADCMC_RSP_GAP_CYC ((`ADCMC_RSP_GAP_NS + `ADCMC_CLK_NS - 1) / `ADCMC_CLK_NS)
`define ADCMC_PWRUP_CYC ((`ADCMC_PWRUP_NS + `ADCMC_CLK_NS - 1) / `ADCMC_CLK_NS)
`define ADCMC_CONT_WIN_CYC 2

`endif

// [hdl/adcmc_pkg.sv]
// Purpose: Types of the converter controller
// Assumes: Nothing
// Notes: Imported by no file; every use is scoped
package adcmc_pkg;

  // ----------------------------------------
  // Command stream and response carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_CONVERT = 2'h1,
    OP_PWRDOWN = 2'h2
  } adcmc_op_e;

  typedef struct packed {
    adcmc_op_e op;
    logic [5:0] slot;
    logic sop;
    logic eop;
  } adcmc_cmd_s;

  typedef struct packed {
    logic valid;
    logic [5:0] slot;
    logic [4:0] channel;
    logic sop;
    logic eop;
  } adcmc_rsp_s;

  // Control core states
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_PWRUP = 6'h02,
    ST_IDLE = 6'h04,
    ST_CONV = 6'h08,
    ST_SYNC = 6'h10,
    ST_GAP = 6'h20
  } adcmc_state_e;

endpackage

// [hdl/adcmc_sample_ram.sv]
// Purpose: Sample store, one entry per sequence slot
// Assumes: One write and one read port on ref_clk
// Notes: Read data is registered, one cycle behind the address
`timescale 1ns/1ps
module adcmc_sample_ram #(
  parameter int W = 12,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  logic [W-1:0] mem [DEPTH];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // No reset on the array so it maps to block RAM
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// [hdl/adcmc_threshold.sv]
// Purpose: Limit check on each response sample of one converter
// Assumes: Samples arrive as one-cycle valid pulses
// Notes: Limits and enables are fixed at build time
`timescale 1ns/1ps
module adcmc_threshold #(
  parameter logic [31:0] MAX_EN = 32'h0000_0000,
  parameter logic [31:0] MIN_EN = 32'h0000_0000,
  parameter logic [11:0] MAX_VAL = 12'hFFF,
  parameter logic [11:0] MIN_VAL = 12'h000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic smpValid,
  input wire logic [4:0] smpChannel,
  input wire logic [11:0] smpData,
  output logic violValid,
  output logic [4:0] violChannel,
  output logic violAboveMax,
  output logic violBelowMin
);
  // ----------------------------------------
  // Compare
  // ----------------------------------------
  wire overMax = MAX_EN[smpChannel] && (smpData > MAX_VAL);
  wire underMin = MIN_EN[smpChannel] && (smpData < MIN_VAL);

  // Violation reported as a one-cycle stream transfer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      violValid <= 1'b0;
      violChannel <= 5'h00;
      violAboveMax <= 1'b0;
      violBelowMin <= 1'b0;
    end else begin
      violValid <= smpValid & (overMax | underMin);
      violChannel <= smpChannel;
      violAboveMax <= smpValid & overMax;
      violBelowMin <= smpValid & underMin;
    end
  end
endmodule

// [verification/adcmc_top_monitor.sv]
// Purpose: Port checks of the converter controller
// Assumes: Single-converter build, one clock domain
// Notes: Bound into adcmc_top at the foot of this file
`timescale 1ns/1ps
module adcmc_top_monitor #(
  parameter int SEQ_LEN = 4,
  parameter logic [319:0] SLOT_CH = 320'h88C41
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic irqEnable,
  input wire logic irq,
  input wire logic [0:0] adcSoc,
  input wire logic [0:0] adcPowerDown,
  input wire logic [0:0] adcTempSense,
  input wire logic [4:0] adcChanSel,
  input wire logic [0:0] adcEoc,
  input wire adcmc_pkg::adcmc_rsp_s resp,
  input wire logic [0:0] violValid,
  input wire logic [0:0] violAboveMax,
  input wire logic [0:0] violBelowMin
);
  // ----------------------------------------
  // Helper ages
  // ----------------------------------------
  logic [7:0] gap_r;
  logic [7:0] eocAge_r;
  logic eocPrev_r;
  logic [5:0] lastSlot_r;
  wire logic eocRise = adcEoc[0] & ~eocPrev_r;
  // Ages saturate at FF so a long quiet spell never wraps into a false match
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 8'hFF;
      eocAge_r <= 8'hFF;
      eocPrev_r <= 1'b0;
      lastSlot_r <= 6'h00;
    end else begin
      gap_r <= resp.valid ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
      eocAge_r <= eocRise ? 8'h00 : eocAge_r + {7'h00, eocAge_r != 8'hFF};
      eocPrev_r <= adcEoc[0];
      lastSlot_r <= resp.valid ? resp.slot : lastSlot_r;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence blockEnd;
    resp.valid && resp.eop && irqEnable;
  endsequence
  sequence midPass;
    resp.valid && !resp.sop;
  endsequence
  chk_rsp_spacing: assert property (resp.valid |-> gap_r >= 8'h31)
    else $error("Responses closer than 50 cycles");
  chk_eoc_to_rsp: assert property (resp.valid |-> eocAge_r inside {[8'h02:8'h06]})
    else $error("Response not tied to a conversion end");
  chk_slot_next: assert property (midPass |-> resp.slot == lastSlot_r + 6'h01)
    else $error("Slot out of order");
  chk_pass_bounds: assert property (resp.valid |->
    resp.sop == (resp.slot == 6'h00) && resp.eop == (resp.slot == 6'(SEQ_LEN - 1)))
    else $error("Start or end marker on wrong slot");
  chk_slot_channel: assert property (resp.valid |->
    resp.channel == SLOT_CH[resp.slot * 5 +: 5])
    else $error("Channel does not match slot table");
  chk_tsd_select: assert property (adcTempSense[0] |-> adcChanSel == 5'h00)
    else $error("Temperature select with pin channel");
  chk_soc_off: assert property (adcPowerDown[0] && $past(adcPowerDown[0]) |-> !adcSoc[0])
    else $error("Start while powered down");
  chk_irq_set: assert property (blockEnd |=> irq)
    else $error("Block end did not raise irq");
  chk_irq_cause: assert property ($rose(irq) |-> $past(resp.valid && resp.eop && irqEnable))
    else $error("irq rose without an enabled block end");
  chk_viol_kind: assert property (violValid[0] |-> violAboveMax[0] || violBelowMin[0])
    else $error("Violation without a kind");
endmodule

bind adcmc_top adcmc_top_monitor #(.SEQ_LEN(SEQ_LEN), .SLOT_CH(SLOT_CH)) mon (
  .ref_clk(ref_clk), .resetn(resetn), .irqEnable(irqEnable), .irq(irq),
  .adcSoc(adcSoc), .adcPowerDown(adcPowerDown), .adcTempSense(adcTempSense),
  .adcChanSel(adcChanSel), .adcEoc(adcEoc), .resp(resp), .violValid(violValid),
  .violAboveMax(violAboveMax), .violBelowMin(violBelowMin)
);

// [verification/adcmc_adc_model.sv]
// Purpose: Behavioural hard converter facing the controller
// Assumes: One converter; conversion time counted in ref_clk cycles
// Notes: slow doubles the conversion time
`timescale 1ns/1ps
module adcmc_adc_model #(
  parameter int CONV_CYC = 60,
  parameter int EOC_CYC = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic adcSoc,
  input wire logic adcPowerDown,
  input wire logic adcTempSense,
  input wire logic [4:0] adcChanSel,
  output logic adcEoc,
  output logic [11:0] adcDout,
  output logic [11:0] lastData
);
  int cnt_r;
  logic [7:0] seq_r;
  // Sensor reads high, pins low, so the limit checks see both kinds
  wire logic [11:0] smp = adcTempSense ? {4'hF, seq_r} : {4'h0, seq_r ^ {3'h0, adcChanSel}};
  // Data holds only while end of conversion is high; otherwise it churns
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 0;
      seq_r <= 8'h00;
      adcEoc <= 1'b0;
      adcDout <= 12'hA5A;
      lastData <= 12'h000;
    end else if (!adcSoc || adcPowerDown) begin
      cnt_r <= 0;
      adcEoc <= 1'b0;
      adcDout <= ~adcDout;
    end else if (cnt_r == (slow ? 2 * CONV_CYC : CONV_CYC)) begin
      cnt_r <= 0;
      adcEoc <= 1'b1;
      seq_r <= seq_r + 8'h01;
      adcDout <= smp;
      lastData <= smp;
    end else begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == EOC_CYC) adcEoc <= 1'b0;
      if (!adcEoc) adcDout <= ~adcDout;
    end
  end
endmodule

// [verification/tb_modular_adc_controller.sv]
// Purpose: Self-checking bench of the converter controller
// Assumes: Slot table 1, 2, 3, sensor; limits on sensor and channel 1
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module tb_modular_adc_controller;
  localparam logic [319:0] SLOT_CH = 320'h88C41;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic seqCmdWrite = 1'b0;
  logic [1:0] seqCmdWdata = 2'h0;
  logic [5:0] ramRdAddr = 6'h00;
  logic irqEnable = 1'b0;
  logic irqClear = 1'b0;
  logic slow = 1'b0;
  logic [1:0] seqCmdRdata;
  logic [11:0] ramRdData, adcDout, respData, lastData;
  logic irq, adcSoc, adcPowerDown, adcTempSense, adcEoc;
  logic violValid, violAboveMax, violBelowMin;
  logic [4:0] adcChanSel, violChannel;
  adcmc_pkg::adcmc_rsp_s resp;
  logic [11:0] expRam [4];
  int fails = 0;
  int tests_run = 0;
  int nAbove = 0;
  int nBelow = 0;

  adcmc_top #(.MAX_EN(32'h0002_0000), .MIN_EN(32'h0000_0002), .MAX_VAL(12'hE00),
    .MIN_VAL(12'h800)) dut (.ref_clk(ref_clk), .resetn(resetn), .seqCmdWrite(seqCmdWrite),
    .seqCmdWdata(seqCmdWdata), .seqCmdRdata(seqCmdRdata), .ramRdAddr(ramRdAddr),
    .ramRdData(ramRdData), .irqEnable(irqEnable), .irqClear(irqClear), .irq(irq),
    .adcSoc(adcSoc), .adcPowerDown(adcPowerDown), .adcTempSense(adcTempSense),
    .adcChanSel(adcChanSel), .adcEoc(adcEoc), .adcDout(adcDout), .resp(resp),
    .respData(respData), .violValid(violValid), .violChannel(violChannel),
    .violAboveMax(violAboveMax), .violBelowMin(violBelowMin));
  adcmc_adc_model model (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .adcSoc(adcSoc),
    .adcPowerDown(adcPowerDown), .adcTempSense(adcTempSense), .adcChanSel(adcChanSel),
    .adcEoc(adcEoc), .adcDout(adcDout), .lastData(lastData));

  // ----------------------------------------
  // Clock, tallies and shared tasks
  // ----------------------------------------
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // A violation on the wrong channel is not counted, so totals expose it
  always @(posedge ref_clk) begin
    if (violValid === 1'b1 && violAboveMax === 1'b1 && violChannel === 5'h11) nAbove++;
    if (violValid === 1'b1 && violBelowMin === 1'b1 && violChannel === 5'h01) nBelow++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic write_cmd(input logic [1:0] d);
    @(negedge ref_clk);
    seqCmdWrite = 1'b1;
    seqCmdWdata = d;
    @(negedge ref_clk);
    seqCmdWrite = 1'b0;
    check(seqCmdRdata, d);
  endtask
  // Responses have no stall, so every pulse is caught in its own cycle
  task automatic get_resp(input int s);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (resp.valid !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    check(resp.valid, 1'h1);
    check(resp.slot, s);
    check(resp.channel, SLOT_CH[s * 5 +: 5]);
    check({resp.sop, resp.eop}, {s == 0, s == 3});
    check(respData, lastData);
    expRam[s] = lastData;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(negedge ref_clk);
    check(adcPowerDown, 1'h1);
    check({irq, seqCmdRdata, resp.valid, adcSoc}, 5'h00);
  endtask
  task automatic t_single();
    irqEnable = 1'b1;
    write_cmd(2'h1);
    for (int s = 0; s < 4; s++) get_resp(s);
    @(negedge ref_clk);
    check(irq, 1'h1);
    repeat (3) @(negedge ref_clk);
    check(nAbove, 1'h1);
    check(nBelow, 1'h1);
    check(seqCmdRdata, 2'h0);
    repeat (120) @(negedge ref_clk);
    check(adcPowerDown, 1'h1);
    for (int s = 0; s < 4; s++) begin
      ramRdAddr = 6'(s);
      @(negedge ref_clk);
      check(ramRdData, expRam[s]);
    end
    irqClear = 1'b1;
    @(negedge ref_clk);
    irqClear = 1'b0;
    check(irq, 1'h0);
  endtask
  // Slow conversions, masked irq; clearing run lets the pass finish, then stops
  task automatic t_continuous();
    int n;
    n = 0;
    slow = 1'b1;
    irqEnable = 1'b0;
    write_cmd(2'h3);
    // The sequencer answers ready at once, so the start stays up between slots
    for (int i = 0; i < 6; i++) begin
      get_resp(i % 4);
      check(adcSoc, 1'h1);
    end
    write_cmd(2'h2);
    get_resp(2);
    get_resp(3);
    repeat (400) begin
      @(negedge ref_clk);
      if (resp.valid !== 1'b0) n++;
    end
    check(n, 0);
    check(irq, 1'h0);
  endtask

  // Full run is under two thousand cycles; this span leaves wide margin
  initial begin
    #1_000_000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset();
    t_single();
    t_continuous();
    wrap_up();
  end
endmodule
